// file: dv/rco_cal_output_sva.sv
// Port checker for the calibration output block, bound to the top module
`timescale 1ns/100ps
module rco_cal_output_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic deepestPowerSavingMode,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port0Bit5PinOut,
    input wire logic port0Bit5PinOeN,
    input wire logic port0Bit7PinOut,
    input wire logic port0Bit7PinOeN,
    input wire logic port1Bit2PinOut,
    input wire logic port1Bit2PinOeN,
    input wire logic port2Bit3PinOeN,
    input wire logic timekeepFastMode
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Pins one edge behind the deep mode input, so the past value is the cause
    a_released_low: assert property (port0Bit7PinOeN |-> !port0Bit7PinOut)
        else $error("released pin shows a high level");
    a_pins_in_phase: assert property (!port0Bit5PinOeN && !port1Bit2PinOeN |->
        port0Bit5PinOut == port1Bit2PinOut)
        else $error("driven pins out of phase");
    a_deep_p07_off: assert property ($past(deepestPowerSavingMode) |-> port0Bit7PinOeN)
        else $error("port0 bit7 driven in deep mode");
    a_deep_others_off: assert property ($past(deepestPowerSavingMode) |->
        port1Bit2PinOeN && port2Bit3PinOeN)
        else $error("port1 or port2 pin driven in deep mode");
    a_deep_fast_off: assert property ($past(deepestPowerSavingMode) && timekeepFastMode |->
        port0Bit5PinOeN)
        else $error("fast code drives a pin in deep mode");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    c_pulse_high: cover property (!port0Bit5PinOeN && port0Bit5PinOut);
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_deep_keep: cover property (deepestPowerSavingMode && !port0Bit5PinOeN);
endmodule

bind rco_cal_output rco_cal_output_sva i_sva (
    .clk, .reset_n, .deepestPowerSavingMode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .port0Bit5PinOut, .port0Bit5PinOeN, .port0Bit7PinOut, .port0Bit7PinOeN,
    .port1Bit2PinOut, .port1Bit2PinOeN, .port2Bit3PinOeN, .timekeepFastMode
);

// file: dv/tb.sv
// Self-checking bench for the calibration output block
`timescale 1ns/100ps
`include "rco_defs.svh"
module tb;
    logic        clk, reset_n, tickSlow, tickFast, deepestPowerSavingMode, timekeepFastMode;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, oeN;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        port0Bit5PinOut, port0Bit5PinOeN, port0Bit7PinOut, port0Bit7PinOeN;
    logic        port1Bit2PinOut, port1Bit2PinOeN, port2Bit3PinOut, port2Bit3PinOeN;
    int          failures, samples_checked;
    localparam logic [11:0] CFG = `RCO_CFG_IDX << `RCO_IDX_LSB;
    localparam logic [11:0] STS = `RCO_STAT_IDX << `RCO_IDX_LSB;
    localparam logic [11:0] BAD = 12'h080;

    // Override enables gathered, port0 bit5 in bit 0
    assign oeN = {port2Bit3PinOeN, port1Bit2PinOeN, port0Bit7PinOeN, port0Bit5PinOeN};

    rco_cal_output i_dut (
        .clk, .reset_n, .tickSlow, .tickFast, .deepestPowerSavingMode, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port0Bit5PinOut, .port0Bit5PinOeN, .port0Bit7PinOut,
        .port0Bit7PinOeN, .port1Bit2PinOut, .port1Bit2PinOeN, .port2Bit3PinOut,
        .port2Bit3PinOeN, .timekeepFastMode
    );

    // Free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A hung handshake or pulse ends the run rather than stalling it
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            $display("ERROR wait limit expected %0d seen %0d", lim, n);
            tally_and_finish();
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            #1;
        end while ((s_axi_awvalid || s_axi_wvalid) && n < 50);
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        bound(n, 50);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] m,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            #1;
        end while (s_axi_arvalid && n < 50);
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        bound(n, 50);
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata & m);
        chk("rresp", er, s_axi_rresp);
    endtask

    task automatic wr_cfg(input logic [31:0] d);
        axi_wr(CFG, d, 4'hF, `RCO_RESP_OKAY);
        repeat (2) @(posedge clk);
    endtask

    task automatic t_bus();
        axi_rd(CFG, 32'h0, 32'hFFFFFFFF, `RCO_RESP_OKAY);
        axi_wr(CFG, 32'h41, 4'hE, `RCO_RESP_OKAY);
        axi_rd(CFG, 32'h0, 32'hFFFFFFFF, `RCO_RESP_OKAY);
        axi_wr(BAD, 32'h41, 4'hF, `RCO_RESP_SLVERR);
        axi_rd(BAD, 32'h0, 32'hFFFFFFFF, `RCO_RESP_SLVERR);
        axi_wr(STS, 32'hFF, 4'hF, `RCO_RESP_OKAY);
        wr_cfg(32'hFFFFFF0A);
        axi_rd(CFG, 32'h0A, 32'hFFFFFFFF, `RCO_RESP_OKAY);
        chk("oe_n disabled", 4'hF, oeN);
        $display("bus test done");
    endtask

    task automatic t_route();
        for (int i = 0; i < 4; i++) begin
            wr_cfg(32'h40 | (1 << i));
            chk("oe_n one pin", 4'(~(4'h1 << i)), oeN);
        end
        wr_cfg(32'h0F);
        chk("oe_n enable off", 4'hF, oeN);
        wr_cfg(32'h4F);
        chk("oe_n all pins", 4'h0, oeN);
        $display("route test done");
    endtask

    task automatic t_deep();
        deepestPowerSavingMode <= 1'b1;
        wr_cfg(32'hCF);
        chk("oe_n deep keep", 4'hE, oeN);
        wr_cfg(32'h4F);
        chk("oe_n deep no keep", 4'hF, oeN);
        wr_cfg(32'hFF);
        chk("oe_n deep fast", 4'hF, oeN);
        axi_rd(STS, 32'h2, 32'h2, `RCO_RESP_OKAY);
        deepestPowerSavingMode <= 1'b0;
        repeat (2) @(posedge clk);
        chk("oe_n awake fast", 4'h0, oeN);
        $display("deep test done");
    endtask

    // Ticks every cycle, so a half period is the tick count in clock cycles
    task automatic t_freq();
        int half [4] = '{16384, 32, 4096, 128};
        int n;
        tickSlow <= 1'b1;
        tickFast <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr_cfg(32'h4F | (c << 4));
            chk("fast mode", c[1], timekeepFastMode);
            n = 0;
            while (port0Bit5PinOut !== 1'b1 && n < 40000) begin
                @(posedge clk);
                n++;
            end
            bound(n, 40000);
            // All four routed pins must show the same high level
            chk("outs in phase", 4'hF, {port2Bit3PinOut, port1Bit2PinOut, port0Bit7PinOut,
                port0Bit5PinOut});
            n = 0;
            while (port0Bit5PinOut !== 1'b0 && n < 40000) begin
                @(posedge clk);
                n++;
            end
            chk("half period", half[c], n);
        end
        $display("frequency test done");
    endtask

    // Every input defined at time zero, reset held two cycles
    initial begin
        failures = 0;
        samples_checked = 0;
        {reset_n, tickSlow, tickFast, deepestPowerSavingMode} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk("oe_n reset", 4'hF, oeN);
        t_bus();
        t_route();
        t_deep();
        t_freq();
        tally_and_finish();
    end
endmodule

// file: logic/rco_cal_output.sv
// Calibration output configuration register, AXI4-Lite slave and pin steering
`timescale 1ns/100ps

module rco_cal_output
    import rco_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   tickSlow,
    input  wire logic                   tickFast,
    input  wire logic                   deepestPowerSavingMode,
    input  wire logic [`RCO_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`RCO_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        port0Bit5PinOut,
    output logic                        port0Bit5PinOeN,
    output logic                        port0Bit7PinOut,
    output logic                        port0Bit7PinOeN,
    output logic                        port1Bit2PinOut,
    output logic                        port1Bit2PinOeN,
    output logic                        port2Bit3PinOut,
    output logic                        port2Bit3PinOeN,
    output logic                        timekeepFastMode
);
    rco_state_s q;
    rco_state_s d;
    logic       rstSync1Q;
    logic       rstN;
    logic       pulse;
    logic       genEnable;
    logic       deepFast;
    logic [`RCO_NPINS-1:0] pinActive;

    // Field views of the configuration register
    logic                  calEnable;
    logic                  deepSleepPulseKeep;
    rco_fsel_e             pulseFrequencySelect;
    logic [`RCO_NPINS-1:0] route;

    assign deepSleepPulseKeep   = q.cfg[`RCO_BIT_KEEP];
    assign calEnable            = q.cfg[`RCO_BIT_EN];
    assign pulseFrequencySelect = rco_fsel_e'(q.cfg[`RCO_FSEL_HI:`RCO_FSEL_LO]);
    assign route                = q.cfg[`RCO_ROUTE_HI:`RCO_ROUTE_LO];

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1Q <= 1'b0;
            rstN      <= 1'b0;
        end else begin
            rstSync1Q <= 1'b1;
            rstN      <= rstSync1Q;
        end
    end

    // Register index from a byte address; used by both read and write decode
    function automatic logic [`RCO_ADDR_W-1:0] regIdx(input logic [`RCO_ADDR_W-1:0] a);
        return {{`RCO_IDX_LSB{1'b0}}, a[`RCO_ADDR_W-1:`RCO_IDX_LSB]};
    endfunction

    function automatic logic isFastSel(input rco_fsel_e sel);
        return (sel == FSEL_500HZ) || (sel == FSEL_16KHZ);
    endfunction

    // Fast codes are not offered in the deepest mode, so the pulse stops there
    assign deepFast  = deepestPowerSavingMode && isFastSel(pulseFrequencySelect);
    assign genEnable = calEnable && !deepFast;

    rco_pulse_gen u_gen (
        .clk      (clk),
        .rstN     (rstN),
        .tickSlow (tickSlow),
        .tickFast (tickFast),
        .freqSel  (pulseFrequencySelect),
        .enable   (genEnable),
        .pulse    (pulse)
    );

    // Per-pin override; bit index 0..3 = port0 bit5, port0 bit7, port1 bit2, port2 bit3
    generate
        for (genvar i = 0; i < `RCO_NPINS; i++) begin : g_pin
            if (i == `RCO_PIN_P0B5) begin : g_keep
                // Only this pin survives deep sleep, and only with the keep bit
                assign pinActive[i] = genEnable && route[i] &&
                                      (!deepestPowerSavingMode || deepSleepPulseKeep);
            end else begin : g_plain
                assign pinActive[i] = genEnable && route[i] &&
                                      !deepestPowerSavingMode;
            end
        end
    endgenerate

    // Next state: bus slave, configuration store and registered pin drive
    always_comb begin
        logic [31:0] status;
        logic        doWrite;
        logic        doRead;
        status = 32'h0000_0000;
        doWrite = 1'b0;
        doRead = 1'b0;
        d = q;

        // Address and data are taken in either order and held until the write lands
        if (s_axi_awvalid && q.awRdy) begin
            d.awHeld = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wRdy) begin
            d.wHeld = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        if (q.bValid && s_axi_bready) begin
            d.bValid = 1'b0;
        end
        doWrite = q.awHeld && q.wHeld && !q.bValid;
        if (doWrite) begin
            d.awHeld = 1'b0;
            d.wHeld = 1'b0;
            d.bValid = 1'b1;
            d.bResp = `RCO_RESP_OKAY;
            if (regIdx(q.awAddr) == `RCO_CFG_IDX) begin
                if (q.wStrb[0]) begin
                    d.cfg = q.wData[7:0];
                end
            end else if (regIdx(q.awAddr) != `RCO_STAT_IDX) begin
                d.bResp = `RCO_RESP_SLVERR;
            end
        end
        // Ready is withdrawn while a channel holds an item, so no second write overlaps
        d.awRdy = !d.awHeld && !d.bValid;
        d.wRdy = !d.wHeld && !d.bValid;

        // Status view of the block's own activity
        status[`RCO_ST_LEVEL] = pulse;
        status[`RCO_ST_DEEP] = deepestPowerSavingMode;
        status[`RCO_ST_FAST] = q.fastMode;
        status[`RCO_ST_RUN] = genEnable;

        // Reads answer one cycle after the address is taken
        if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end
        doRead = s_axi_arvalid && q.arRdy;
        if (doRead) begin
            d.rValid = 1'b1;
            d.rResp = `RCO_RESP_OKAY;
            if (regIdx(s_axi_araddr) == `RCO_CFG_IDX) begin
                d.rData = {24'h00_0000, q.cfg};
            end else if (regIdx(s_axi_araddr) == `RCO_STAT_IDX) begin
                d.rData = status;
            end else begin
                d.rData = 32'h0000_0000;
                d.rResp = `RCO_RESP_SLVERR;
            end
        end
        d.arRdy = !d.rValid;

        // Pin drive one cycle behind the generator; idle pins hand back to their port
        for (int i = 0; i < `RCO_NPINS; i++) begin
            d.pinOut[i] = pinActive[i] && pulse;
            d.pinOeN[i] = !pinActive[i];
        end

        // Timekeeping counters run 125x faster while a fast code is selected
        d.fastMode = isFastSel(rco_fsel_e'(d.cfg[`RCO_FSEL_HI:`RCO_FSEL_LO]));
    end

    // State register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '{cfg: `RCO_CFG_RESET, awRdy: 1'b0, awHeld: 1'b0, awAddr: '0,
                   wRdy: 1'b0, wHeld: 1'b0, wData: '0, wStrb: '0,
                   bValid: 1'b0, bResp: `RCO_RESP_OKAY, arRdy: 1'b0,
                   rValid: 1'b0, rData: '0, rResp: `RCO_RESP_OKAY,
                   pinOut: '0, pinOeN: '1, fastMode: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready    = q.awRdy;
    assign s_axi_wready     = q.wRdy;
    assign s_axi_bvalid     = q.bValid;
    assign s_axi_bresp      = q.bResp;
    assign s_axi_arready    = q.arRdy;
    assign s_axi_rvalid     = q.rValid;
    assign s_axi_rdata      = q.rData;
    assign s_axi_rresp      = q.rResp;
    assign port0Bit5PinOut  = q.pinOut[0];
    assign port0Bit5PinOeN  = q.pinOeN[0];
    assign port0Bit7PinOut  = q.pinOut[1];
    assign port0Bit7PinOeN  = q.pinOeN[1];
    assign port1Bit2PinOut  = q.pinOut[2];
    assign port1Bit2PinOeN  = q.pinOeN[2];
    assign port2Bit3PinOut  = q.pinOut[3];
    assign port2Bit3PinOeN  = q.pinOeN[3];
    assign timekeepFastMode = q.fastMode;
endmodule

// file: logic/rco_pulse_gen.sv
// Square-wave calibration pulse generator driven by the RTC timebase ticks
`timescale 1ns/100ps
module rco_pulse_gen
    import rco_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstN,
    input  wire logic      tickSlow,
    input  wire logic      tickFast,
    input  wire rco_fsel_e freqSel,
    input  wire logic      enable,
    output logic           pulse
);
    rco_gen_s q;
    rco_gen_s d;

    // Half period for each frequency code
    function automatic rco_cnt_t halfCount(input rco_fsel_e sel);
        rco_cnt_t r;
        r = `RCO_HALF_1HZ;
        unique case (sel)
            FSEL_1HZ:   r = `RCO_HALF_1HZ;
            FSEL_512HZ: r = `RCO_HALF_512HZ;
            FSEL_500HZ: r = `RCO_HALF_500HZ;
            FSEL_16KHZ: r = `RCO_HALF_16KHZ;
        endcase
        return r;
    endfunction

    // Fast codes count the sped-up timebase, normal codes the 32.768 kHz one
    function automatic logic isFast(input rco_fsel_e sel);
        return (sel == FSEL_500HZ) || (sel == FSEL_16KHZ);
    endfunction

    // Restart from low on any change of code or enable so no runt half-period escapes
    always_comb begin
        logic tick;
        tick = isFast(freqSel) ? tickFast : tickSlow;
        d = q;
        d.lastSel = freqSel;
        d.lastEn = enable;
        if (!enable || (freqSel != q.lastSel) || !q.lastEn) begin
            d.cnt = '0;
            d.level = 1'b0;
        end else if (tick) begin
            if (q.cnt == halfCount(freqSel) - 14'h0001) begin
                d.cnt = '0;
                d.level = ~q.level;
            end else begin
                d.cnt = q.cnt + 14'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '{cnt: '0, level: 1'b0, lastSel: FSEL_1HZ, lastEn: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign pulse = q.level;
endmodule

// file: pkg/rco_defs.svh
// Offsets, field positions, reset values and timing counts of the calibration output block
`ifndef RCO_DEFS_SVH
`define RCO_DEFS_SVH

// Register indices; byte address is four times the index
`define RCO_CFG_IDX        12'h00F
`define RCO_STAT_IDX       12'h010
`define RCO_ADDR_W         12
`define RCO_IDX_LSB        2

// Configuration register fields
`define RCO_CFG_RESET      8'h00
`define RCO_BIT_KEEP       7
`define RCO_BIT_EN         6
`define RCO_FSEL_HI        5
`define RCO_FSEL_LO        4
`define RCO_ROUTE_HI       3
`define RCO_ROUTE_LO       0
`define RCO_PIN_P0B5       0
`define RCO_NPINS          4

// Status register fields
`define RCO_ST_LEVEL       0
`define RCO_ST_DEEP        1
`define RCO_ST_FAST        2
`define RCO_ST_RUN         3

// Half-period counts in timebase ticks (slow tick 32.768 kHz, fast tick 125x faster)
`define RCO_HALF_1HZ       14'h4000
`define RCO_HALF_512HZ     14'h0020
`define RCO_HALF_500HZ     14'h1000
`define RCO_HALF_16KHZ     14'h0080
`define RCO_CNT_W          14
`define RCO_SPEEDUP        125

// AXI response codes
`define RCO_RESP_OKAY      2'h0
`define RCO_RESP_SLVERR    2'h2

`endif

// file: pkg/rco_pkg.sv
// Types shared by the calibration output block
package rco_pkg;
    `include "rco_defs.svh"

    typedef enum logic [1:0] {
        FSEL_1HZ,
        FSEL_512HZ,
        FSEL_500HZ,
        FSEL_16KHZ
    } rco_fsel_e;

    typedef logic [`RCO_CNT_W-1:0] rco_cnt_t;

    typedef struct packed {
        rco_cnt_t  cnt;
        logic      level;
        rco_fsel_e lastSel;
        logic      lastEn;
    } rco_gen_s;

    typedef struct packed {
        logic [7:0]             cfg;
        logic                   awRdy;
        logic                   awHeld;
        logic [`RCO_ADDR_W-1:0] awAddr;
        logic                   wRdy;
        logic                   wHeld;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bValid;
        logic [1:0]             bResp;
        logic                   arRdy;
        logic                   rValid;
        logic [31:0]            rData;
        logic [1:0]             rResp;
        logic [`RCO_NPINS-1:0]  pinOut;
        logic [`RCO_NPINS-1:0]  pinOeN;
        logic                   fastMode;
    } rco_state_s;
endpackage
